// File: logic/ckd_clock_ctrl.sv
`timescale 1ns/1ps
`include "ckd_params.svh"
// Functional notes
// - main oscillator frequency chosen from six codes, each with its own trim
// - doubler gives a tick on both source edges, twice the input rate
// - doubler source is main oscillator, fast crystal or fabric clock
// - pll multiply range kept usable for its 24 to 67 MHz output band
// - pll input divider 1..16 and feedback 4..255 give 4032 ratios
// - lock flag sets after the lock time, also driven out to fabric
// - pll reference is main oscillator, fast crystal or fabric clock
// - low speed oscillator yields 1k, 33k and 100k clock ticks
// - slow periodic counter is 13 bits, advanced by the 1k tick
// - slow counter freezes in hibernate and while debug halts the cpu
// - firmware clear forces the slow counter to zero
// - slow counter match gives a periodic wake, optionally an interrupt
// - fast counter is 5 bits on 100k, wraps to zero at terminal count
// - fast counter raises an interrupt at each terminal count when enabled
// - 33k tick is the 100k tick divided by three
// - watch crystal feeds sleep tick and a once per second interrupt
// - each digital divider may take its own routed fabric clock
// - bus clock divider runs from the system clock, cpu clock equals bus clock
// - four analog dividers have a skew delay to dodge digital edges
// - every divider: 8-way mux, ratio at least two, near 50% duty, resynced
// - digital divider outputs go out so the fabric can chain them back
module ckd_clock_ctrl #(
	parameter int unsigned LOCK_CYC = `CKD_PLL_LOCK_NS * `CKD_MCLK_MHZ / 1000
) (
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [31:0]                 reg_rdata,
	input  wire logic                   hibernate,
	input  wire logic                   debug_halt,
	input  wire logic                   imo_clk_in,
	input  wire logic                   eco_clk_in,
	input  wire logic                   fabric_clk_in,
	input  wire logic                   pll_clk_in,
	input  wire logic                   ilo_1k_in,
	input  wire logic                   ilo_100k_in,
	input  wire logic                   watch_clk_in,
	input  wire logic [7:0]             fabric_div_clk,
	output ckd_pkg::ckd_imo_freq_t      imo_freq,
	output logic [7:0]                  imo_trim,
	output logic                        dbl_tick,
	output logic                        pll_en,
	output ckd_pkg::ckd_ref_t           pll_ref_sel,
	output logic [4:0]                  pll_in_div,
	output logic [7:0]                  pll_fb_div,
	output logic                        pll_ref_tick,
	output logic                        pll_lock,
	output logic                        low_speed_clock_1k,
	output logic                        low_speed_clock_100k,
	output logic                        low_speed_clock_33k,
	output logic                        slow_wake,
	output logic                        slow_irq,
	output logic                        fast_irq,
	output logic                        sleep_tick,
	output logic                        rtc_second_irq,
	output logic                        bus_clk,
	output logic                        cpu_clk,
	output logic [7:0]                  dig_clk,
	output logic [3:0]                  ana_clk,
	output logic [12:0]                 div_tick
);
	import ckd_pkg::*;

	localparam logic [17:0] LOCK_END  = 18'(LOCK_CYC - 1);
	localparam logic [14:0] WATCH_END = 15'(`CKD_WATCH_HZ - 1);

	logic [14:0] pin_meta;
	logic [14:0] pin_sync;
	logic [14:0] pin_last;
	logic [14:0] rise;
	logic [14:0] edge_any;
	logic        imo_t;
	logic        eco_t;
	logic        fab_t;
	logic        pll_t;
	logic        t1k;
	logic        t100k;
	logic        watch_t;
	logic [7:0]  fdiv_t;
	logic        wr_imo;
	logic        wr_dbl;
	logic        wr_pll;
	logic        wr_slow;
	logic        wr_fast;
	logic        dbl_en;
	ckd_ref_t    dbl_src;
	logic [17:0] lock_cnt;
	logic [1:0]  div3;
	logic [12:0] slow_cnt;
	logic [12:0] slow_match;
	logic        slow_wake_en;
	logic        slow_ien;
	logic        slow_clr;
	logic        slow_run;
	logic        slow_evt;
	logic [4:0]  fast_cnt;
	logic [4:0]  fast_term;
	logic        fast_ien;
	logic        fast_end;
	logic [14:0] watch_cnt;
	logic [31:0] rd_val;
	logic [4:0]  pll_q;
	logic [12:0] div_clk;
	logic [31:0] div_ctl_rd [`CKD_NUM_DIV];
	logic [15:0] div_rat_rd [`CKD_NUM_DIV];

	// three-way reference picker shared by doubler and pll
	function automatic logic ref_pick(input ckd_ref_t s, input logic [2:0] v);
		logic r;
		r = 1'b0;
		unique case (s)
			ckd_ref_imo: r = v[0];
			ckd_ref_eco: r = v[1];
			ckd_ref_fab: r = v[2];
			ckd_ref_off: r = 1'b0;
		endcase
		return r;
	endfunction : ref_pick

	// trim lookup; codes six and seven never get stored
	function automatic logic [7:0] trim_of(input ckd_imo_freq_t f);
		logic [7:0] t;
		t = `CKD_TRIM_0;
		unique case (f)
			ckd_imo_3:  t = `CKD_TRIM_0;
			ckd_imo_6:  t = `CKD_TRIM_1;
			ckd_imo_12: t = `CKD_TRIM_2;
			ckd_imo_24: t = `CKD_TRIM_3;
			ckd_imo_48: t = `CKD_TRIM_4;
			ckd_imo_62: t = `CKD_TRIM_5;
			default:    t = `CKD_TRIM_0;
		endcase
		return t;
	endfunction : trim_of

	// every oscillator and fabric clock is foreign: two flops, then edge flop
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta <= 15'h0000;
			pin_sync <= 15'h0000;
			pin_last <= 15'h0000;
		end else begin
			pin_meta <= {fabric_div_clk, watch_clk_in, ilo_100k_in, ilo_1k_in,
				pll_clk_in, fabric_clk_in, eco_clk_in, imo_clk_in};
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	// sources faster than mclk/2 alias; the fastest one, 67 MHz, still fits
	assign rise     = pin_sync & ~pin_last;
	assign edge_any = pin_sync ^ pin_last;
	assign imo_t    = rise[0];
	assign eco_t    = rise[1];
	assign fab_t    = rise[2];
	assign pll_t    = rise[3];
	assign t1k      = rise[4];
	assign t100k    = rise[5];
	assign watch_t  = rise[6];
	assign fdiv_t   = rise[14:7];

	// register write decode
	assign wr_imo  = reg_wr && (reg_addr == `CKD_OFS_IMO);
	assign wr_dbl  = reg_wr && (reg_addr == `CKD_OFS_DBL);
	assign wr_pll  = reg_wr && (reg_addr == `CKD_OFS_PLL);
	assign wr_slow = reg_wr && (reg_addr == `CKD_OFS_SLOW);
	assign wr_fast = reg_wr && (reg_addr == `CKD_OFS_FAST);

	// main oscillator code; out-of-range codes are ignored, not stored
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			imo_freq <= ckd_imo_3;
			imo_trim <= `CKD_TRIM_0;
		end else begin
			if (wr_imo && reg_wdata[2:0] <= `CKD_IMO_MAX)
				imo_freq <= ckd_imo_freq_t'(reg_wdata[2:0]);
			imo_trim <= trim_of(imo_freq);
		end
	end

	// doubler: a tick on each edge of its source doubles the rate
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dbl_en   <= 1'b0;
			dbl_src  <= ckd_ref_imo;
			dbl_tick <= 1'b0;
		end else begin
			if (wr_dbl) begin
				dbl_en  <= reg_wdata[0];
				dbl_src <= ckd_ref_t'(reg_wdata[2:1]);
			end
			dbl_tick <= dbl_en && ref_pick(dbl_src, edge_any[2:0]);
		end
	end

	// pll configuration; feedback floor keeps the ratio count at 4032
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pll_en       <= 1'b0;
			pll_ref_sel  <= ckd_ref_imo;
			pll_in_div   <= 5'h01;
			pll_fb_div   <= `CKD_PLL_P_RST;
			pll_ref_tick <= 1'b0;
		end else begin
			if (wr_pll) begin
				pll_en      <= reg_wdata[0];
				pll_ref_sel <= ckd_ref_t'(reg_wdata[2:1]);
				pll_in_div  <= {1'b0, reg_wdata[7:4]} + 5'h01;
				pll_fb_div  <= (reg_wdata[15:8] < `CKD_PLL_P_MIN) ?
					`CKD_PLL_P_MIN : reg_wdata[15:8];
			end
			pll_ref_tick <= pll_en && ref_pick(pll_ref_sel, rise[2:0]);
		end
	end

	// lock timer restarts on any pll write; a rewrite beats a same-cycle lock
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_cnt <= 18'h00000;
			pll_lock <= 1'b0;
		end else if (!pll_en || wr_pll) begin
			lock_cnt <= 18'h00000;
			pll_lock <= 1'b0;
		end else if (!pll_lock) begin
			if (lock_cnt == LOCK_END)
				pll_lock <= 1'b1;
			else
				lock_cnt <= lock_cnt + 18'h00001;
		end
	end

	// low speed ticks; 33k is every third 100k tick
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			div3                 <= 2'h0;
			low_speed_clock_1k   <= 1'b0;
			low_speed_clock_100k <= 1'b0;
			low_speed_clock_33k  <= 1'b0;
		end else begin
			if (t100k)
				div3 <= (div3 == `CKD_ILO_DIV) ? 2'h0 : div3 + 2'h1;
			low_speed_clock_1k   <= t1k;
			low_speed_clock_100k <= t100k;
			low_speed_clock_33k  <= t100k && (div3 == `CKD_ILO_DIV);
		end
	end

	assign slow_clr = wr_slow && reg_wdata[`CKD_SLOW_CLR_BIT];
	assign slow_run = !hibernate && !debug_halt;
	assign slow_evt = slow_run && t1k && !slow_clr && (slow_cnt == slow_match);

	// slow counter settings
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			slow_match   <= 13'h1fff;
			slow_wake_en <= 1'b0;
			slow_ien     <= 1'b0;
		end else if (wr_slow) begin
			slow_match   <= reg_wdata[12:0];
			slow_wake_en <= reg_wdata[`CKD_SLOW_WAKE_BIT];
			slow_ien     <= reg_wdata[`CKD_SLOW_IEN_BIT];
		end
	end

	// free running; a clear wins over a tick in the same cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			slow_cnt  <= 13'h0000;
			slow_wake <= 1'b0;
			slow_irq  <= 1'b0;
		end else begin
			if (slow_clr)
				slow_cnt <= 13'h0000;
			else if (slow_run && t1k)
				slow_cnt <= slow_cnt + 13'h0001;
			slow_wake <= slow_evt && slow_wake_en;
			slow_irq  <= slow_evt && slow_ien;
		end
	end

	// fast counter; >= rather than == so a lowered terminal cannot strand it
	assign fast_end = t100k && (fast_cnt >= fast_term);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fast_term <= 5'h1f;
			fast_ien  <= 1'b0;
			fast_cnt  <= 5'h00;
			fast_irq  <= 1'b0;
		end else begin
			if (wr_fast) begin
				fast_term <= reg_wdata[4:0];
				fast_ien  <= reg_wdata[`CKD_FAST_IEN_BIT];
			end
			if (fast_end)
				fast_cnt <= 5'h00;
			else if (t100k)
				fast_cnt <= fast_cnt + 5'h01;
			fast_irq <= fast_end && fast_ien;
		end
	end

	// watch crystal: sleep tick per rising edge, one pulse per 32768 rising edges
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			watch_cnt      <= 15'h0000;
			sleep_tick     <= 1'b0;
			rtc_second_irq <= 1'b0;
		end else begin
			if (watch_t)
				watch_cnt <= (watch_cnt == WATCH_END) ? 15'h0000 : watch_cnt + 15'h0001;
			sleep_tick     <= watch_t;
			rtc_second_irq <= watch_t && (watch_cnt == WATCH_END);
		end
	end

	// divider bank: index 0 bus, 1..8 digital, 9..12 analog
	for (genvar i = 0; i < `CKD_NUM_DIV; i++) begin : g_div
		logic [7:0] src;
		logic       wr_c;
		logic       wr_r;
		logic       en;
		ckd_sel_t   sel;
		ckd_ratio_t ratio;
		ckd_ratio_t skew;

		assign wr_c     = reg_wr && (reg_addr == 8'(`CKD_OFS_DIV + `CKD_DIV_STRIDE * i));
		assign wr_r     = reg_wr && (reg_addr ==
			8'(`CKD_OFS_DIV + `CKD_DIV_STRIDE * i + `CKD_DIV_RAT_OFS));
		assign src[6:0] = {watch_t, t100k, dbl_tick, pll_t, fab_t, eco_t, imo_t};
		if (i >= 1 && i <= `CKD_NUM_DIG) begin : g_dig
			assign src[7] = fdiv_t[i - 1];
		end else begin : g_sys
			assign src[7] = 1'b1; // system clock: every mclk cycle
		end

		// bus divider is pinned to the system clock; only analog ones skew
		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				en    <= (i == 0);
				sel   <= `CKD_SYS_SEL;
				ratio <= `CKD_DIV_RATIO_RST;
				skew  <= 16'h0000;
			end else begin
				if (wr_c) begin
					en   <= reg_wdata[0];
					sel  <= (i == 0) ? `CKD_SYS_SEL : reg_wdata[3:1];
					skew <= (i >= `CKD_FIRST_ANA) ? reg_wdata[31:16] : 16'h0000;
				end
				if (wr_r)
					ratio <= reg_wdata[15:0];
			end
		end

		assign div_ctl_rd[i] = {skew, 12'h000, sel, en};
		assign div_rat_rd[i] = ratio;

		ckd_divider u_div (
			.mclk    (mclk),
			.sys_rst (sys_rst),
			.src_tick(src),
			.en      (en),
			.sel     (sel),
			.ratio   (ratio),
			.skew    (skew),
			.clk_out (div_clk[i]),
			.tick    (div_tick[i])
		);
	end

	// clock tree outputs; digital ones are what the fabric chains back
	assign bus_clk = div_clk[0];
	assign cpu_clk = bus_clk;
	assign dig_clk = div_clk[8:1];
	assign ana_clk = div_clk[12:9];

	// input divider reads back as the written code, so a read fits the write layout
	assign pll_q = pll_in_div - 5'h01;

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (reg_addr)
			`CKD_OFS_IMO:  rd_val = {16'h0000, imo_trim, 5'h00, imo_freq};
			`CKD_OFS_DBL:  rd_val = {29'h0, dbl_src, dbl_en};
			`CKD_OFS_PLL:  rd_val = {pll_lock, 15'h0000, pll_fb_div,
				pll_q[3:0], 1'b0, pll_ref_sel, pll_en};
			`CKD_OFS_SLOW: rd_val = {17'h0, slow_ien, slow_wake_en, slow_match};
			`CKD_OFS_SCNT: rd_val = {19'h0, slow_cnt};
			`CKD_OFS_FAST: rd_val = {19'h0, fast_cnt, 2'h0, fast_ien, fast_term};
			default:       rd_val = 32'h0000_0000;
		endcase
		for (int k = 0; k < `CKD_NUM_DIV; k++) begin
			if (reg_addr == 8'(`CKD_OFS_DIV + `CKD_DIV_STRIDE * k))
				rd_val = div_ctl_rd[k];
			if (reg_addr == 8'(`CKD_OFS_DIV + `CKD_DIV_STRIDE * k + `CKD_DIV_RAT_OFS))
				rd_val = {16'h0000, div_rat_rd[k]};
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
	end

	property p_slow_hold;
		@(posedge mclk) disable iff (sys_rst)
			((hibernate || debug_halt) && !slow_clr) |=> $stable(slow_cnt);
	endproperty
	a_slow_hold: assert property (p_slow_hold)
		else $error("slow counter moved while frozen");

	property p_slow_clr;
		@(posedge mclk) disable iff (sys_rst) slow_clr |=> slow_cnt == 13'h0000;
	endproperty
	a_slow_clr: assert property (p_slow_clr)
		else $error("slow counter not cleared");

	property p_slow_step;
		@(posedge mclk) disable iff (sys_rst)
			(slow_run && t1k && !slow_clr) |=> slow_cnt == $past(slow_cnt) + 13'h0001;
	endproperty
	a_slow_step: assert property (p_slow_step)
		else $error("slow counter missed a 1k tick");

	property p_fast_wrap;
		@(posedge mclk) disable iff (sys_rst)
			fast_end |=> (fast_cnt == 5'h00) && (fast_irq == $past(fast_ien));
	endproperty
	a_fast_wrap: assert property (p_fast_wrap)
		else $error("fast counter wrap or interrupt wrong");

	property p_lock_needs_en;
		@(posedge mclk) disable iff (sys_rst)
			$rose(pll_lock) |-> ($past(pll_en) && $past(lock_cnt) == LOCK_END);
	endproperty
	a_lock_needs_en: assert property (p_lock_needs_en)
		else $error("lock rose early or while disabled");

	property p_lock_drop;
		@(posedge mclk) disable iff (sys_rst) (!pll_en || wr_pll) |=> !pll_lock;
	endproperty
	a_lock_drop: assert property (p_lock_drop)
		else $error("lock held after disable or rewrite");

	property p_div3;
		@(posedge mclk) disable iff (sys_rst)
			low_speed_clock_33k |-> (low_speed_clock_100k && div3 == 2'h0);
	endproperty
	a_div3: assert property (p_div3)
		else $error("33k tick off the third 100k tick");

	property p_rtc;
		@(posedge mclk) disable iff (sys_rst)
			rtc_second_irq |-> (sleep_tick && watch_cnt == 15'h0000);
	endproperty
	a_rtc: assert property (p_rtc)
		else $error("second pulse not at watch wrap");

	c_pll_lock: cover property (@(posedge mclk) disable iff (sys_rst) $rose(pll_lock));
	c_fast_irq: cover property (@(posedge mclk) disable iff (sys_rst) fast_irq);
	c_slow_wake: cover property (@(posedge mclk) disable iff (sys_rst) slow_wake);
endmodule : ckd_clock_ctrl

// File: pkg/ckd_params.svh
`ifndef CKD_PARAMS_SVH
`define CKD_PARAMS_SVH
// timing base
`define CKD_MCLK_MHZ      250
`define CKD_PLL_LOCK_NS   250000
`define CKD_WATCH_HZ      32768
`define CKD_ILO_DIV       2'h2
// divider population: one bus, eight digital, four analog
`define CKD_NUM_DIV       13
`define CKD_NUM_DIG       8
`define CKD_FIRST_ANA     9
// register byte offsets
`define CKD_OFS_IMO       8'h00
`define CKD_OFS_DBL       8'h04
`define CKD_OFS_PLL       8'h08
`define CKD_OFS_SLOW      8'h0c
`define CKD_OFS_SCNT      8'h10
`define CKD_OFS_FAST      8'h14
`define CKD_OFS_DIV       8'h40
`define CKD_DIV_STRIDE    8'h08
`define CKD_DIV_RAT_OFS   8'h04
// field positions
`define CKD_SLOW_WAKE_BIT 13
`define CKD_SLOW_IEN_BIT  14
`define CKD_SLOW_CLR_BIT  15
`define CKD_FAST_IEN_BIT  5
`define CKD_PLL_LOCK_BIT  31
// reset values and limits
`define CKD_IMO_MAX       3'h5
`define CKD_DIV_RATIO_RST 16'h0002
`define CKD_DIV_RATIO_MIN 16'h0002
`define CKD_PLL_P_MIN     8'h04
`define CKD_PLL_P_RST     8'h10
`define CKD_SYS_SEL       3'h7
// factory trim per frequency code, values arbitrary
`define CKD_TRIM_0        8'h80
`define CKD_TRIM_1        8'h81
`define CKD_TRIM_2        8'h82
`define CKD_TRIM_3        8'h83
`define CKD_TRIM_4        8'h84
`define CKD_TRIM_5        8'h85
`endif

// File: pkg/ckd_pkg.sv
package ckd_pkg;
	typedef logic [2:0]  ckd_sel_t;
	typedef logic [15:0] ckd_ratio_t;
	typedef enum logic [2:0] {
		ckd_imo_3  = 3'b000,
		ckd_imo_6  = 3'b001,
		ckd_imo_12 = 3'b010,
		ckd_imo_24 = 3'b011,
		ckd_imo_48 = 3'b100,
		ckd_imo_62 = 3'b101
	} ckd_imo_freq_t;
	typedef enum logic [1:0] {
		ckd_ref_imo = 2'b00,
		ckd_ref_eco = 2'b01,
		ckd_ref_fab = 2'b10,
		ckd_ref_off = 2'b11
	} ckd_ref_t;
endpackage : ckd_pkg

// File: logic/ckd_divider.sv
`timescale 1ns/1ps
`include "ckd_params.svh"
module ckd_divider (
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire logic [7:0]          src_tick,
	input  wire logic                en,
	input  wire ckd_pkg::ckd_sel_t   sel,
	input  wire ckd_pkg::ckd_ratio_t ratio,
	input  wire ckd_pkg::ckd_ratio_t skew,
	output logic                     clk_out,
	output logic                     tick
);
	import ckd_pkg::*;
	ckd_sel_t   cur_sel;
	ckd_ratio_t cur_ratio;
	ckd_ratio_t eff;
	ckd_ratio_t cnt;
	ckd_ratio_t dly;
	ckd_ratio_t next_cnt;
	ckd_ratio_t half;
	logic       run;
	logic       next_run;
	logic       src;
	logic       wrap;

	// 8-input source mux, ratio floored at two
	assign src  = src_tick[cur_sel];
	assign eff  = (ratio < `CKD_DIV_RATIO_MIN) ? `CKD_DIV_RATIO_MIN : ratio;
	assign wrap = run && src && (cnt == cur_ratio - 16'h0001);
	assign half = {1'b0, cur_ratio[15:1]};

	// stop only at a period end, so disabling never clips a pulse
	always_comb begin
		next_run = run ? !(wrap && !en) : (en && src && (dly == 16'h0000));
		next_cnt = cnt;
		if (!next_run || !run)
			next_cnt = 16'h0000;
		else if (src)
			next_cnt = wrap ? 16'h0000 : cnt + 16'h0001;
	end

	// new mux/ratio only taken between periods, so no short pulse
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_sel   <= `CKD_SYS_SEL;
			cur_ratio <= `CKD_DIV_RATIO_RST;
		end else if (!run || wrap) begin
			cur_sel   <= sel;
			cur_ratio <= eff;
		end
	end

	// skew delay counts source ticks before the first period
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			dly <= 16'h0000;
		else if (!run && !en)
			dly <= skew;
		else if (!run && src && (dly != 16'h0000))
			dly <= dly - 16'h0001;
	end

	// output is a flop on mclk: resynchronised and glitch free
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			run     <= 1'b0;
			cnt     <= 16'h0000;
			clk_out <= 1'b0;
			tick    <= 1'b0;
		end else begin
			run     <= next_run;
			cnt     <= next_cnt;
			clk_out <= next_run && (next_cnt < half);
			tick    <= next_run && (wrap || !run);
		end
	end

	property p_div_ratio_floor;
		@(posedge mclk) disable iff (sys_rst) run |-> cur_ratio >= 16'h0002;
	endproperty
	a_div_ratio_floor: assert property (p_div_ratio_floor)
		else $error("divider running with ratio below two");

	property p_div_cfg_hold;
		@(posedge mclk) disable iff (sys_rst)
			(run && !wrap) |=> ($stable(cur_ratio) && $stable(cur_sel));
	endproperty
	a_div_cfg_hold: assert property (p_div_cfg_hold)
		else $error("divider config changed mid period");

	property p_div_tick_high;
		@(posedge mclk) disable iff (sys_rst) tick |-> (clk_out && run && cnt == 16'h0000);
	endproperty
	a_div_tick_high: assert property (p_div_tick_high)
		else $error("period start without high output");

	property p_div_duty;
		@(posedge mclk) disable iff (sys_rst) ($fell(clk_out) && run) |-> cnt == half;
	endproperty
	a_div_duty: assert property (p_div_duty)
		else $error("output fell away from half period");

	c_div_tick: cover property (@(posedge mclk) disable iff (sys_rst) tick ##[1:40] tick);
endmodule : ckd_divider

// File: verif/ckd_osc_model.sv
`timescale 1ns/1ps
// oscillator stand-ins; half periods avoid rising mclk edges so sync delays stay fixed
module ckd_osc_model (
	output logic       main_internal_osc,
	output logic       eco,
	output logic       fab,
	output logic       pll,
	output logic       k1,
	output logic       k100,
	output logic       watch,
	output logic [7:0] fdiv
);
	initial {main_internal_osc, eco, fab, pll, k1, k100, watch, fdiv} = '0;
	// low speed sources run at 64 and 16 mclk periods to keep the run short
	always #128 k1 = ~k1;
	always #32 k100 = ~k100;
	always #8 main_internal_osc = ~main_internal_osc;
	always #12 eco = ~eco;
	always #20 fab = ~fab;
	always #16 pll = ~pll;
	always #24 watch = ~watch;
	always #28 fdiv = ~fdiv;
endmodule : ckd_osc_model

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int LOCK = 20;
	logic        mclk, sys_rst, reg_wr, reg_rd, hibernate, debug_halt;
	logic [7:0]  reg_addr, fdiv, imo_trim;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic        main_internal_osc, eco, fab, pll, k1, k100, watch, pll_lock, fast_irq, k33t, k100t;
	logic        dbl_t, s_wake;
	logic [12:0] div_tick;
	int          n_mismatch, n_checks;
	wire  [6:0]  ev = {s_wake, dbl_t, div_tick[1], div_tick[0], fast_irq, k33t, k100t};

	ckd_osc_model osc (.main_internal_osc(main_internal_osc), .eco(eco), .fab(fab), .pll(pll), .k1(k1), .k100(k100),
		.watch(watch), .fdiv(fdiv));
	ckd_clock_ctrl #(.LOCK_CYC(LOCK)) dut (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hibernate(hibernate),
		.debug_halt(debug_halt), .imo_clk_in(main_internal_osc), .eco_clk_in(eco), .fabric_clk_in(fab),
		.pll_clk_in(pll), .ilo_1k_in(k1), .ilo_100k_in(k100), .watch_clk_in(watch),
		.fabric_div_clk(fdiv), .imo_freq(), .imo_trim(imo_trim), .dbl_tick(dbl_t), .pll_en(),
		.pll_ref_sel(), .pll_in_div(), .pll_fb_div(), .pll_ref_tick(), .pll_lock(pll_lock),
		.low_speed_clock_1k(), .low_speed_clock_100k(k100t), .low_speed_clock_33k(k33t),
		.slow_wake(s_wake), .slow_irq(), .fast_irq(fast_irq), .sleep_tick(), .rtc_second_irq(),
		.bus_clk(), .cpu_clk(), .dig_clk(), .ana_clk(), .div_tick(div_tick));

	// 250 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// cycles between two pulses of one event; a lost event ends the run
	task automatic gap(input int idx, input int exp, input string what);
		int n;
		int c;
		n = 0;
		c = 0;
		do begin @(posedge mclk); #1 n++; end while (ev[idx] !== 1'b1 && n < 500);
		do begin @(posedge mclk); #1 c++; end while (ev[idx] !== 1'b1 && c < 500);
		chk(what, exp, c);
		if (n >= 500)
			n_mismatch++;
		if (n >= 500 || c >= 500)
			end_sim();
	endtask : gap

	task automatic t_regs();
		rd(8'h3c, rv);
		chk("unmapped", 32'h0, rv);
		rd(8'h00, rv);
		chk("imo reset", 32'h0000_8000, rv);
		wr(8'h00, 32'h5);
		rd(8'h00, rv);
		chk("imo 62", 32'h0000_8505, rv);
		chk("trim pin", 32'h85, {24'h0, imo_trim});
		wr(8'h00, 32'h6);
		rd(8'h00, rv);
		chk("imo code 6", 32'h0000_8505, rv);
		$display("test regs done");
	endtask : t_regs

	task automatic t_pll();
		wr(8'h08, 32'h1001);
		repeat (LOCK - 1) @(posedge mclk);
		#1 chk("lock early", 32'h0, pll_lock);
		@(posedge mclk);
		#1 chk("lock due", 32'h1, pll_lock);
		rd(8'h08, rv);
		chk("pll read", 32'h8000_1001, rv);
		wr(8'h08, 32'h0);
		rd(8'h08, rv);
		chk("pll off", 32'h0000_0400, rv);
		$display("test pll done");
	endtask : t_pll

	task automatic t_slow();
		int n;
		@(posedge mclk);
		hibernate <= 1'b1;
		wr(8'h0c, 32'h8000);
		rd(8'h10, rv);
		chk("slow clear", 32'h0, rv);
		repeat (200) @(posedge mclk);
		rd(8'h10, rv);
		chk("slow hib", 32'h0, rv);
		@(posedge mclk);
		hibernate  <= 1'b0;
		debug_halt <= 1'b1;
		repeat (200) @(posedge mclk);
		rd(8'h10, rv);
		chk("slow dbg", 32'h0, rv);
		@(posedge mclk);
		debug_halt <= 1'b0;
		repeat (200) @(posedge mclk);
		rd(8'h10, rv);
		chk("slow runs", 32'h1, {31'h0, rv != 0});
		// clear, match 2, wake enabled: wake follows the tick that leaves count 2
		wr(8'h0c, 32'ha002);
		n = 0;
		do begin @(posedge mclk); #1 n++; end while (ev[6] !== 1'b1 && n < 500);
		rd(8'h10, rv);
		chk("slow wake", 32'h3, (n < 500) ? rv : 32'hffff_ffff);
		$display("test slow done");
	endtask : t_slow

	task automatic t_wheels();
		gap(0, 16, "tick 100k");
		gap(1, 48, "tick 33k");
		wr(8'h14, 32'h22);
		gap(2, 48, "fast irq");
		$display("test wheels done");
	endtask : t_wheels

	task automatic t_div();
		wr(8'h44, 32'h4);
		gap(3, 4, "bus ratio 4");
		wr(8'h44, 32'h1);
		gap(3, 2, "bus ratio 1");
		$display("test div done");
	endtask : t_div

	// doubler on the main oscillator, digital divider 1 on the 100k tick
	task automatic t_src();
		wr(8'h04, 32'h1);
		gap(5, 2, "doubler imo");
		wr(8'h48, 32'hb);
		gap(4, 32, "dig 100k ratio 2");
		$display("test src done");
	endtask : t_src

	// reset, then each scenario in turn
	initial begin
		{sys_rst, reg_wr, reg_rd, hibernate, debug_halt, reg_addr, reg_wdata} = '0;
		sys_rst = 1'b1;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_pll();
		t_slow();
		t_wheels();
		t_div();
		t_src();
		end_sim();
	end
endmodule : testbench
